/* verilog/pfm_consts.svh */
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH
// Register byte addresses
`define PFM_ADDR_SET        32'h4002_8100
`define PFM_ADDR_CLR        32'h4002_8104
`define PFM_ADDR_STATE      32'h4002_8108
// Reset value of the selection state
`define PFM_STATE_RESET     32'h0000_0000
// Implemented selection bits: 15, 12, 10, 9, 8, 6, 5, 4, 3, 2
`define PFM_SEL_MASK        32'h0000_977C
// Selection bits that the LCD may take over: 15, 8, 6, 5
`define PFM_LCD_MASK        32'h0000_8160
// Selection bits that the motor PWM takes over: 10, 9
`define PFM_MOTOR_MASK      32'h0000_0600
// Timer 0 match select field in the clear register
`define PFM_T0_MSB          20
`define PFM_T0_LSB          17
`define PFM_T0_RESET        4'h0
`endif

/* verilog/pfm_pkg.sv */
package pfm_pkg;
  // Register targeted by the pending data phase, one-hot
  typedef enum logic [3:0] {
    PFM_REG_NONE  = 4'b0001,
    PFM_REG_SET   = 4'b0010,
    PFM_REG_CLR   = 4'b0100,
    PFM_REG_STATE = 4'b1000
  } pfm_reg_t;

  // All state of the mux block
  typedef struct packed {
    logic [31:0] sel;          // Selection state, one bit a pin
    logic [3:0]  t0;           // Timer 0 match requests, bit 3 = match 0
    pfm_reg_t    dp_reg;       // Register of the data phase
    logic        dp_wr;        // Data phase is a write
    logic [31:0] hrdata;       // Read data
    logic        hreadyout;    // Always ready
    logic [31:0] func_alt;     // Alternate function after overrides
    logic [3:0]  lcd_route;    // LCD owns pins of bits 15, 8, 6, 5
    logic [1:0]  motor_route;  // Motor feedback two / one own pins 10 / 9
    logic        card_route;   // Card data lines own the shared pins
    logic [3:0]  t0_route;     // Timer 0 match 0..3 drive the shared pins
  } pfm_state_t;
endpackage

/* verilog/pfm_periph_mux.sv */
`timescale 1ns/1ps
`include "pfm_consts.svh"
// How it works
// - Set and clear registers read as zero
// - Set ones select alternate function
// - Clear ones restore default function
// - State reflects all prior set/clear writes
// - State zero default, one alternate
// - State layout as set, resets zero
// - Bit 15: uart seven tx / timer1 match1
// - Bit 12: spi a clock / ssp a clock
// - Bits 10, 9: spi a data / ssp a
// - Motor PWM enable routes motor feedback
// - Bits 8,6,5: spi b / ssp b
// - Bits 4,3,2: audio b tx / timer3
// - LCD enable may override bits 15,8,6,5
// - Clear bits 20..17 select timer0 matches
// - Card interface beats timer0 match selections
// - State register is read only
// - Card enabled when control bit 10 low
module pfm_periph_mux
  import pfm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Override conditions from neighbouring blocks, same clock
  input  wire logic        lcd_enable,
  input  wire logic        motor_pwm_enable,
  input  wire logic        card_pins_disable,
  // Pin routing, all registered
  output logic      [31:0] func_alt,
  output logic      [3:0]  lcd_route,
  output logic      [1:0]  motor_route,
  output logic             card_route,
  output logic      [3:0]  t0_route
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  pfm_state_t st_r;          // Registered state
  pfm_state_t st_nxt;        // Next state
  logic       take;          // Address phase accepted
  logic [31:0] sel_upd;      // Selection after this cycle's write
  logic [3:0]  t0_upd;       // Timer 0 requests after this cycle's write
  logic        card_en;      // Card interface owns its pins

  // Zero wait states: every accepted address phase is followed by a data
  // phase in the very next cycle, so no stall logic is needed
  // Accept a transfer only when the bus is ready; busy and idle are dropped
  assign take    = hsel & htrans[1] & hready;
  assign card_en = ~card_pins_disable;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // One pass works out the selection after any write in the current data
  // phase, then decodes the new address phase and the pin routes from it.
  // Routes use the updated selection so pins move at the write's own edge.
  always_comb begin
    st_nxt  = st_r;
    sel_upd = st_r.sel;
    t0_upd  = st_r.t0;
    // Data phase write lands on the selection
    if (st_r.dp_wr) begin
      case (st_r.dp_reg)
        PFM_REG_SET: begin
          // Zero bits leave pins alone, reserved ones are masked off
          sel_upd = st_r.sel | (hwdata & `PFM_SEL_MASK);
        end
        PFM_REG_CLR: begin
          sel_upd = st_r.sel & ~(hwdata & `PFM_SEL_MASK);
          // Match request bits only ever add a route until reset
          t0_upd  = st_r.t0 | hwdata[`PFM_T0_MSB:`PFM_T0_LSB];
        end
        // State register writes are ignored
        PFM_REG_STATE: begin
          sel_upd = st_r.sel;
        end
        default: begin
          sel_upd = st_r.sel;
        end
      endcase
    end
    st_nxt.sel       = sel_upd;
    st_nxt.t0        = t0_upd;
    st_nxt.hreadyout = 1'b1;
    // Address phase decode
    st_nxt.dp_reg    = PFM_REG_NONE;
    st_nxt.dp_wr     = 1'b0;
    st_nxt.hrdata    = 32'h0000_0000;
    if (take) begin
      st_nxt.dp_wr = hwrite;
      if (haddr == `PFM_ADDR_SET) begin
        st_nxt.dp_reg = PFM_REG_SET;
      end else if (haddr == `PFM_ADDR_CLR) begin
        st_nxt.dp_reg = PFM_REG_CLR;
      end else if (haddr == `PFM_ADDR_STATE) begin
        st_nxt.dp_reg = PFM_REG_STATE;
        // Read sees the write that finishes in this cycle
        if (!hwrite) begin
          st_nxt.hrdata = sel_upd;
        end
      end else begin
        // Unmapped: okay, reads zero, writes dropped
        st_nxt.dp_reg = PFM_REG_NONE;
      end
      // Set and clear reads give zero
    end
    // Pin routing, overrides win over the stored selection
    // The LCD takes its four pins as a group, whatever the selection holds;
    // the stored bits survive so the pins return to them once the LCD stops
    st_nxt.lcd_route   = lcd_enable ? 4'hF : 4'h0;
    // Motor feedback takes bits 10 and 9 while the PWM runs
    st_nxt.motor_route = motor_pwm_enable ? 2'b11 : 2'b00;
    // Card lines win whenever the card interface is on; timer 0 requests
    // stay stored and come back when the card interface lets go
    st_nxt.card_route  = card_en;
    st_nxt.t0_route    = card_en ? 4'h0 : t0_upd;
    st_nxt.func_alt    = sel_upd
                         & ~(lcd_enable ? `PFM_LCD_MASK : 32'h0000_0000)
                         & ~(motor_pwm_enable ? `PFM_MOTOR_MASK : 32'h0000_0000);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset values are written out field by field so that the timer 0
  // requests, which nothing but reset can clear, are plainly covered
  // Synchronous reset; every pin starts on its default function
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r.sel         <= `PFM_STATE_RESET;
      st_r.t0          <= `PFM_T0_RESET;
      st_r.dp_reg      <= PFM_REG_NONE;
      st_r.dp_wr       <= 1'b0;
      st_r.hrdata      <= 32'h0000_0000;
      st_r.hreadyout   <= 1'b1;
      st_r.func_alt    <= 32'h0000_0000;
      st_r.lcd_route   <= 4'h0;
      st_r.motor_route <= 2'b00;
      st_r.card_route  <= 1'b0;
      st_r.t0_route    <= 4'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output but hresp, which is tied low, is a plain copy of a flop; no logic sits between the
  // state and the pins, so the routes cannot glitch while inputs settle
  assign hrdata      = st_r.hrdata;
  assign hreadyout   = st_r.hreadyout;
  assign hresp       = 1'b0;
  assign func_alt    = st_r.func_alt;
  assign lcd_route   = st_r.lcd_route;
  assign motor_route = st_r.motor_route;
  assign card_route  = st_r.card_route;
  assign t0_route    = st_r.t0_route;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Write to a register: accepted address phase then its data phase
  sequence s_wr_set;
    take && hwrite && (haddr == `PFM_ADDR_SET) ##1 1'b1;
  endsequence

  sequence s_wr_clr;
    take && hwrite && (haddr == `PFM_ADDR_CLR) ##1 1'b1;
  endsequence

  AST_SET_ONES: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_wr_set |=> st_r.sel == ($past(st_r.sel) | ($past(hwdata) & `PFM_SEL_MASK)))
    else $error("set write did not or in the written ones");

  AST_CLR_ONES: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_wr_clr |=> st_r.sel == ($past(st_r.sel) & ~($past(hwdata) & `PFM_SEL_MASK)))
    else $error("clear write did not remove the written ones");

  AST_STATE_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take && !hwrite && (haddr == `PFM_ADDR_STATE) |=> hrdata == st_r.sel)
    else $error("state read does not show the selection");

  AST_WO_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take && !hwrite && ((haddr == `PFM_ADDR_SET) || (haddr == `PFM_ADDR_CLR)) |=> hrdata == 32'h0000_0000)
    else $error("write-only register read back data");

  AST_RESET_ZERO: assert property (@(posedge clk_sys)
    !rst_n |=> (st_r.sel == `PFM_STATE_RESET) && (func_alt == 32'h0000_0000))
    else $error("selection not zero after reset");

  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.sel & ~`PFM_SEL_MASK) == 32'h0000_0000)
    else $error("reserved state bit set");

  AST_MOTOR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    motor_pwm_enable |=> (motor_route == 2'b11) && (func_alt[10:9] == 2'b00))
    else $error("motor feedback did not take bits 10 and 9");

  AST_LCD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lcd_enable |=> (lcd_route == 4'hF) && ((func_alt & `PFM_LCD_MASK) == 32'h0000_0000))
    else $error("LCD override not applied");

  AST_CARD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !card_pins_disable |=> card_route && (t0_route == 4'h0))
    else $error("card lines did not win over timer 0 matches");

  AST_T0_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_wr_clr ##0 (hwdata[`PFM_T0_MSB] && card_pins_disable) ##1 card_pins_disable |-> t0_route[3])
    else $error("timer 0 match 0 not routed after clear write");

  // ----------------------------------------
  // Checks on selection, routing and read data
  // ----------------------------------------
  // Write aimed at the read-only state register
  sequence s_wr_state;
    take && hwrite && (haddr == `PFM_ADDR_STATE) ##1 1'b1;
  endsequence

  // Read data only stands in the data phase of a state read
  AST_HRDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(take && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data not zero outside a read data phase");

  // Software cannot change the selection through the state register
  AST_STATE_WR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_wr_state |=> st_r.sel == $past(st_r.sel))
    else $error("state register write changed the selection");

  // Without a landing write the selection holds its value
  AST_SEL_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_r.dp_wr |=> st_r.sel == $past(st_r.sel))
    else $error("selection moved without a write");

  // An alternate function is never driven unless the state asks for it
  AST_ALT_SUBSET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (func_alt & ~st_r.sel) == 32'h0000_0000)
    else $error("alternate function driven for a default pin");

  // Bit 15 follows the state while the LCD is off
  AST_BIT15: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !lcd_enable |=> func_alt[15] == st_r.sel[15])
    else $error("bit 15 routing does not follow the selection");

  // Bit 12 has no override at all
  AST_BIT12: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> func_alt[12] == st_r.sel[12])
    else $error("bit 12 routing does not follow the selection");

  // Bits 10 and 9 follow the state while the motor PWM is off
  AST_BITS10_9: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !motor_pwm_enable |=> func_alt[10:9] == st_r.sel[10:9])
    else $error("bits 10 and 9 routing does not follow the selection");

  // Bits 8, 6 and 5 follow the state while the LCD is off
  AST_BITS8_6_5: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !lcd_enable |=> {func_alt[8], func_alt[6:5]} == {st_r.sel[8], st_r.sel[6:5]})
    else $error("bits 8, 6 and 5 routing does not follow the selection");

  // Bits 4 to 2 have no override at all
  AST_BITS4_2: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> func_alt[4:2] == st_r.sel[4:2])
    else $error("bits 4 to 2 routing does not follow the selection");

  // With the card interface off, its pins go back to the mux
  AST_CARD_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    card_pins_disable |=> !card_route)
    else $error("card lines kept their pins while disabled");

  // With the card interface off, the stored timer 0 requests show
  AST_T0_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    card_pins_disable |=> t0_route == st_r.t0)
    else $error("timer 0 routes do not show the stored requests");

  // Motor feedback lets go of its pins when the PWM stops
  AST_MOTOR_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !motor_pwm_enable |=> motor_route == 2'b00)
    else $error("motor feedback kept its pins");

  // The LCD lets go of its pins when it is disabled
  AST_LCD_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !lcd_enable |=> lcd_route == 4'h0)
    else $error("LCD kept its pins while disabled");

endmodule

/* verification/test_peripheral_pin_function_mux.sv */
`timescale 1ns/1ps
`include "pfm_consts.svh"
module test_peripheral_pin_function_mux
  import pfm_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;             // Word transfers only
  logic [31:0] hwdata = 32'h0000_0000;
  logic        lcd_enable = 1'b0;
  logic        motor_pwm_enable = 1'b0;
  logic        card_pins_disable = 1'b1; // Card interface off
  logic [31:0] hrdata, func_alt, rd_q, v;
  logic        hreadyout, hresp, card_route;
  logic [3:0]  lcd_route, t0_route;
  logic [1:0]  motor_route;
  int          err_total = 0;
  int          checks_done = 0;
  // Row: address, data, {lcd, motor, card off}, state, timer 0 routes
  typedef struct packed {
    logic [31:0] a, d;
    logic [2:0]  ov;
    logic [31:0] st;
    logic [3:0]  t0;
  } pfm_row_t;
  pfm_row_t rows [9] = '{
    '{`PFM_ADDR_SET, 32'h0000_977C, 3'b001, 32'h0000_977C, 4'h0},
    '{`PFM_ADDR_CLR, 32'h0000_0600, 3'b001, 32'h0000_917C, 4'h0},
    '{`PFM_ADDR_SET, 32'h0000_0000, 3'b001, 32'h0000_917C, 4'h0},
    '{`PFM_ADDR_STATE, 32'hFFFF_FFFF, 3'b101, 32'h0000_917C, 4'h0},
    '{`PFM_ADDR_SET, 32'h0000_0600, 3'b011, 32'h0000_977C, 4'h0},
    '{32'h4002_810C, 32'hFFFF_FFFF, 3'b001, 32'h0000_977C, 4'h0},
    '{`PFM_ADDR_CLR, 32'h0014_977C, 3'b001, 32'h0000_0000, 4'hA},
    '{`PFM_ADDR_CLR, 32'h0000_0000, 3'b000, 32'h0000_0000, 4'h0},
    '{`PFM_ADDR_SET, 32'h0000_0000, 3'b001, 32'h0000_0000, 4'hA}};

  pfm_periph_mux i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lcd_enable(lcd_enable), .motor_pwm_enable(motor_pwm_enable),
    .card_pins_disable(card_pins_disable), .func_alt(func_alt), .lcd_route(lcd_route),
    .motor_route(motor_route), .card_route(card_route), .t0_route(t0_route));

  // ----------------------------------------
  // Clock, read capture, shared tasks
  // ----------------------------------------
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Pre-edge copy of read data, avoids racing the data phase edge
  always @(posedge clk_sys) rd_q <= hrdata;

  task end_of_test;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for ready at a rising edge
  task rdy;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      if (++n > 50) begin
        err_total++;
        end_of_test;
      end
      @(posedge clk_sys);
    end
  endtask
  // One single AHB transfer, address phase then data phase
  task xfer(input logic [31:0] a, input logic [31:0] d, input logic w, output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    rdy;
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    rdy;
    #1 r = rd_q;
  endtask
  task do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    xfer(`PFM_ADDR_STATE, 32'h0, 1'b0, v); chk(v, `PFM_STATE_RESET);
    xfer(`PFM_ADDR_SET, 32'h0, 1'b0, v); chk(v, 32'h0);
    xfer(`PFM_ADDR_CLR, 32'h0, 1'b0, v); chk(v, 32'h0);
    xfer(32'h4002_810C, 32'h0, 1'b0, v); chk({v[31:1], hresp}, 32'h0);
    $display("reset and read-back test done");
    // Table of cumulative writes under the override inputs
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      {lcd_enable, motor_pwm_enable, card_pins_disable} <= rows[i].ov;
      xfer(rows[i].a, rows[i].d, 1'b1, v);
      xfer(`PFM_ADDR_STATE, 32'h0, 1'b0, v);
      chk(v, rows[i].st);
      chk(func_alt, rows[i].st & ~({32{rows[i].ov[2]}} & `PFM_LCD_MASK)
        & ~({32{rows[i].ov[1]}} & `PFM_MOTOR_MASK));
      chk(32'({lcd_route, motor_route, card_route, t0_route}), 32'({{4{rows[i].ov[2]}},
        {2{rows[i].ov[1]}}, ~rows[i].ov[0], rows[i].t0}));
    end
    $display("table test done");
    // Each implemented selection bit alone, set then cleared
    for (int b = 0; b < 32; b++) begin
      if (`PFM_SEL_MASK & (32'h1 << b)) begin
        xfer(`PFM_ADDR_SET, 32'h1 << b, 1'b1, v);
        xfer(`PFM_ADDR_STATE, 32'h0, 1'b0, v);
        chk(v, 32'h1 << b);
        chk(func_alt, 32'h1 << b);
        xfer(`PFM_ADDR_CLR, 32'h1 << b, 1'b1, v);
        chk(func_alt, 32'h0);
      end
    end
    $display("single bit test done");
    // Reset in mid-run drops selections and sticky timer requests
    xfer(`PFM_ADDR_SET, 32'h0000_977C, 1'b1, v);
    do_reset;
    xfer(`PFM_ADDR_STATE, 32'h0, 1'b0, v); chk(v, 32'h0);
    chk(32'(t0_route), 32'h0);
    $display("second reset test done");
    end_of_test;
  end
endmodule
